// ===== hdl/apt_map.svh
// Register offsets, field positions, reset values and codes for pair triggers
`ifndef APT_MAP_SVH
`define APT_MAP_SVH
`define APT_OFF_CTRL_1 4'h0
`define APT_OFF_CTRL_3 4'h1
`define APT_OFF_STATUS 4'h2
`define APT_OFF_GLOBAL 4'h3
`define APT_RST_CTRL 16'h0000
`define APT_SEL_LSB 0
`define APT_SEL_MSB 4
`define APT_SWT_BIT 5
`define APT_PEND_BIT 6
`define APT_IRQE_BIT 7
`define APT_TRG_OFF 5'h00
`define APT_TRG_INDIV 5'h01
`define APT_TRG_GLOBAL 5'h02
`define APT_TRG_SPECIAL 5'h03
`define APT_TRG_PRI1 5'h04
`define APT_TRG_PRI2 5'h05
`define APT_TRG_PRI4 5'h07
`define APT_TRG_TMR1 5'h0c
`define APT_TRG_SEC1 5'h0e
`define APT_TRG_SEC2 5'h0f
`define APT_TRG_SEC4 5'h11
`define APT_TRG_CL1 5'h17
`define APT_TRG_CL2 5'h18
`define APT_TRG_CL4 5'h1a
`define APT_TRG_TMR2 5'h1f
`endif

// ===== hdl/apt_pkg.sv
// Types shared by the pair trigger control block
package apt_pkg;
   typedef struct packed {
      logic irq_en;
      logic pending;
      logic soft_trig;
      logic [4:0] sel;
   } apt_pair_t;
   typedef struct packed {
      logic [2:0] pri;
      logic [2:0] sec;
      logic [2:0] climit;
      logic special;
      logic tmr1;
      logic tmr2;
   } apt_trig_t;
   typedef struct packed {
      logic [3:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } apt_bus_t;
   typedef enum logic [1:0] {
      APT_IDLE = 2'b00,
      APT_BUSY = 2'b01
   } apt_conv_t;
   typedef struct packed {
      apt_pair_t [3:0] pair;
      apt_conv_t conv;
      logic [1:0] cur;
      logic [15:0] rdata;
      logic [3:0] conv_req;
      logic [3:0] irq;
      logic [3:0] done_pair;
   } apt_state_t;
endpackage

// ===== hdl/apt_ctrl.sv
// Trigger selection and pending status for four converter pairs
// How it works
// - Each pair holds a 5-bit source selector; zero disables the pair.
// - Code 00001 selects the pair's own software trigger bit.
// - Code 00010 selects the shared global software trigger.
// - Code 00011 selects the PWM special event trigger.
// - Codes 00100, 00101, 00111 select PWM 1, 2, 4 primary triggers.
// - Codes 01110, 01111, 10001 select PWM 1, 2, 4 secondary triggers.
// - Codes 10111, 11000, 11010 select PWM 1, 2, 4 current-limit triggers.
// - Code 01100 selects timer 1 period match; 11111 timer 2.
// - Software trigger bit self-clears when pending sets.
// - Triggered pairs wait until the converter is free.
// - Each byte: selector in bits 4-0, then trigger, pending, enable.
// - Pair six converts channels 13 and 12, selector in ctrl 3 low byte.
// - Channel 13 of pair six is always the voltage reference.
`timescale 1ns/1ps
`default_nettype none
`include "apt_map.svh"
module apt_ctrl (
   input wire logic mclk,
   input wire logic rst,
   input wire apt_pkg::apt_bus_t bus,
   output logic [15:0] rdata,
   input wire apt_pkg::apt_trig_t trig,
   input wire logic conv_done,
   output logic [3:0] conv_req,
   output logic [3:0] pair_irq,
   output logic [3:0] pair_done
);
   import apt_pkg::*;

   apt_state_t s_q;
   apt_state_t s_d;
   logic glob_d;
   logic glob_q;
   logic [3:0] hit;

   // Map selector code to a trigger level
   function automatic logic sel_hit(input logic [4:0] sel,
                                    input logic own_sw,
                                    input logic glob,
                                    input apt_trig_t t);
      logic r;
      r = 1'b0;
      case (sel)
         `APT_TRG_INDIV: r = own_sw;
         `APT_TRG_GLOBAL: r = glob;
         `APT_TRG_SPECIAL: r = t.special;
         `APT_TRG_PRI1: r = t.pri[0];
         `APT_TRG_PRI2: r = t.pri[1];
         `APT_TRG_PRI4: r = t.pri[2];
         `APT_TRG_SEC1: r = t.sec[0];
         `APT_TRG_SEC2: r = t.sec[1];
         `APT_TRG_SEC4: r = t.sec[2];
         `APT_TRG_CL1: r = t.climit[0];
         `APT_TRG_CL2: r = t.climit[1];
         `APT_TRG_CL4: r = t.climit[2];
         `APT_TRG_TMR1: r = t.tmr1;
         `APT_TRG_TMR2: r = t.tmr2;
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   // Pack a pair into its byte lane
   function automatic logic [7:0] pair_byte(input apt_pair_t p);
      return {p.irq_en, p.pending, p.soft_trig, p.sel};
   endfunction

   // Global software trigger is a one-cycle pulse written by software
   assign glob_d = bus.wr && bus.addr == `APT_OFF_GLOBAL && bus.wdata[0];

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         glob_q <= 1'b0;
      end else begin
         glob_q <= glob_d;
      end
   end

   // Trigger detect per pair
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         hit[i] = sel_hit(s_q.pair[i].sel, s_q.pair[i].soft_trig, glob_q,
                          trig);
      end
   end

   // Next state: registers, pending, converter sequencing
   always_comb begin
      logic [7:0] wb;
      logic found;
      logic [1:0] pick;
      wb = 8'h00;
      found = 1'b0;
      pick = 2'b00;
      s_d = s_q;
      s_d.conv_req = 4'h0;
      s_d.irq = 4'h0;
      s_d.done_pair = 4'h0;
      s_d.rdata = 16'h0000;
      // Register writes; pending is read-only from software
      if (bus.wr) begin
         for (int i = 0; i < 4; i++) begin
            if (bus.addr == (i < 2 ? `APT_OFF_CTRL_1 : `APT_OFF_CTRL_3)) begin
               wb = (i % 2 == 0) ? bus.wdata[7:0] : bus.wdata[15:8];
               s_d.pair[i].sel = wb[`APT_SEL_MSB:`APT_SEL_LSB];
               s_d.pair[i].soft_trig = wb[`APT_SWT_BIT];
               s_d.pair[i].irq_en = wb[`APT_IRQE_BIT];
            end
         end
      end
      // A trigger sets pending and retires the software bit; completion clear wins
      for (int i = 0; i < 4; i++) begin
         if (hit[i] && !s_q.pair[i].pending) begin
            s_d.pair[i].pending = 1'b1;
            s_d.pair[i].soft_trig = 1'b0;
         end
      end
      // Converter: serve one pending pair at a time, lowest index first
      unique case (s_q.conv)
         APT_IDLE: begin
            for (int i = 3; i >= 0; i--) begin
               if (s_q.pair[i].pending) begin
                  found = 1'b1;
                  pick = 2'(i);
               end
            end
            if (found) begin
               s_d.cur = pick;
               s_d.conv = APT_BUSY;
               s_d.conv_req[pick] = 1'b1;
            end
         end
         APT_BUSY: begin
            // Hold request until converter reports completion
            s_d.conv_req[s_q.cur] = 1'b1;
            if (conv_done) begin
               s_d.conv_req = 4'h0;
               s_d.pair[s_q.cur].pending = 1'b0;
               s_d.done_pair[s_q.cur] = 1'b1;
               s_d.irq[s_q.cur] = s_q.pair[s_q.cur].irq_en;
               s_d.conv = APT_IDLE;
            end
         end
      endcase
      // Read data appears the cycle after the read strobe
      if (bus.rd) begin
         case (bus.addr)
            `APT_OFF_CTRL_1:
               s_d.rdata = {pair_byte(s_q.pair[1]), pair_byte(s_q.pair[0])};
            `APT_OFF_CTRL_3:
               s_d.rdata = {pair_byte(s_q.pair[3]), pair_byte(s_q.pair[2])};
            `APT_OFF_STATUS:
               s_d.rdata = {11'h000, s_q.conv == APT_BUSY, s_q.pair[3].pending,
                            s_q.pair[2].pending, s_q.pair[1].pending,
                            s_q.pair[0].pending};
            default: s_d.rdata = 16'h0000;
         endcase
      end
   end

   // State register
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs come straight from the state flops
   assign rdata = s_q.rdata;
   // Pair 2 (ctrl 3 low byte) is pair six: channels 13 and 12
   assign conv_req = s_q.conv_req;
   assign pair_irq = s_q.irq;
   assign pair_done = s_q.done_pair;
endmodule
`default_nettype wire

// ===== testbench/apt_ctrl_asserts.sv
// Port timing checker for the pair trigger control block
`timescale 1ns/1ps
`default_nettype none
module apt_ctrl_asserts (
   input wire logic mclk,
   input wire logic rst,
   input wire apt_pkg::apt_bus_t bus,
   input wire logic [15:0] rdata,
   input wire apt_pkg::apt_trig_t trig,
   input wire logic conv_done,
   input wire logic [3:0] conv_req,
   input wire logic [3:0] pair_irq,
   input wire logic [3:0] pair_done
);
   import apt_pkg::*;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // The converter serves one pair at a time
   a_one_owner: assert property ($onehot0(conv_req))
      else $error("several pairs requesting at once");
   a_req_holds: assert property (|conv_req && !conv_done |=>
      $stable(conv_req))
      else $error("request changed before completion");
   a_req_drops: assert property (conv_done && |conv_req |=>
      (conv_req & $past(conv_req)) == 4'h0)
      else $error("request survived completion");
   a_done_cause: assert property (|pair_done |->
      $past(conv_done) && pair_done == $past(conv_req))
      else $error("completion pulse without finished pair");
   a_done_pulse: assert property (|pair_done |=> pair_done == 4'h0)
      else $error("completion pulse too long");
   a_done_free: assert property (conv_done && conv_req == 4'h0 |=>
      pair_done == 4'h0)
      else $error("stray done completed a pair");
   a_irq_subset: assert property ((pair_irq & ~pair_done) == 4'h0)
      else $error("interrupt without completion");
   // Read data only stand in the cycle after a read strobe
   a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 16'h0)
      else $error("read data outside read cycle");
endmodule
`default_nettype wire

// ===== testbench/apt_ctrl_tb.sv
// Self-checking bench for the pair trigger control block
`timescale 1ns/1ps
`default_nettype none
module apt_ctrl_tb;
   import apt_pkg::*;
   logic mclk = 0, rst = 1, conv_done = 0;
   apt_bus_t bus = '0;
   apt_trig_t trig = '0;
   logic [15:0] rdata;
   logic [3:0] conv_req, pair_irq, pair_done;
   int fails = 0, n_compared = 0, cyc = 0;
   // Rows: control byte, trigger pattern, global strobe, request expected
   logic [21:0] rows [18] = '{{8'h21,12'h000,2'b01}, {8'h02,12'h000,2'b11},
      {8'h03,12'h004,2'b01}, {8'h04,12'h200,2'b01}, {8'h05,12'h400,2'b01},
      {8'h07,12'h800,2'b01}, {8'h0e,12'h040,2'b01}, {8'h0f,12'h080,2'b01},
      {8'h11,12'h100,2'b01}, {8'h17,12'h008,2'b01}, {8'h18,12'h010,2'b01},
      {8'h1a,12'h020,2'b01}, {8'h0c,12'h002,2'b01}, {8'h1f,12'h001,2'b01},
      {8'h00,12'hfff,2'b10}, {8'h06,12'hfff,2'b10}, {8'h1b,12'hfff,2'b10},
      {8'h04,12'h400,2'b00}};
   always #50 mclk = ~mclk;
   apt_ctrl u_dut (.mclk(mclk), .rst(rst), .bus(bus), .rdata(rdata),
      .trig(trig), .conv_done(conv_done), .conv_req(conv_req),
      .pair_irq(pair_irq), .pair_done(pair_done));
   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk) begin bus.addr <= a; bus.wdata <= d; bus.wr <= 1; end
      @(posedge mclk) bus.wr <= 0;
   endtask
   task rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge mclk) begin bus.addr <= a; bus.rd <= 1; end
      @(posedge mclk) bus.rd <= 0;
      @(negedge mclk) chk(rdata, e);
   endtask
   // Bounded wait; a request that never comes fails the compare
   // Let a trigger ripple through first so an expected idle is meaningful
   task wait_req(input logic [3:0] e);
      repeat (3) @(negedge mclk);
      for (int i = 0; i < 8 && conv_req !== e; i++) @(negedge mclk);
      chk(conv_req, e);
   endtask
   task done(input logic [3:0] pd, input logic [3:0] pi);
      @(posedge mclk) conv_done <= 1;
      @(posedge mclk) conv_done <= 0;
      @(negedge mclk) chk(pair_done, pd);
      chk(pair_irq, pi);
   endtask
   task wrap_up;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Hang guard well above the expected run length
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         fails++;
         wrap_up;
      end
   end
   initial begin
      repeat (4) @(posedge mclk);
      rst <= 0;
      rd(4'h0, 16'h0000);
      rd(4'h1, 16'h0000);
      foreach (rows[r]) begin
         wr(4'h0, {8'h00, rows[r][21:14] | 8'h80});
         if (rows[r][1]) wr(4'h3, 16'h0001);
         @(posedge mclk) trig <= rows[r][13:2];
         @(posedge mclk) trig <= '0;
         wait_req({3'b000, rows[r][0]});
         if (rows[r][0]) done(4'h1, 4'h1);
         rd(4'h0, {8'h00, rows[r][21:14] & 8'h1f | 8'h80});
         wr(4'h0, 16'h0000);
      end
      // Interrupt enable clear: completion without an interrupt
      wr(4'h0, 16'h0021);
      wait_req(4'h1);
      done(4'h1, 4'h0);
      // One timer tick queues three pairs; they convert one by one
      wr(4'h0, 16'h000c);
      wr(4'h1, 16'h0c0c);
      @(posedge mclk) trig <= 12'h002;
      @(posedge mclk) trig <= '0;
      wait_req(4'h1);
      done(4'h1, 4'h0);
      rd(4'h2, 16'h001c);
      wait_req(4'h4);
      done(4'h4, 4'h0);
      wait_req(4'h8);
      done(4'h8, 4'h0);
      wr(4'h5, 16'hffff);
      rd(4'h5, 16'h0000);
      // A completion with nothing requested must finish no pair
      done(4'h0, 4'h0);
      // Mid-run reset clears a pending pair
      wr(4'h0, 16'h0021);
      @(posedge mclk) rst <= 1;
      repeat (2) @(posedge mclk);
      rst <= 0;
      rd(4'h2, 16'h0000);
      rd(4'h0, 16'h0000);
      wrap_up;
   end
endmodule
bind apt_ctrl apt_ctrl_asserts u_chk (.mclk(mclk), .rst(rst), .bus(bus),
   .rdata(rdata), .trig(trig), .conv_done(conv_done), .conv_req(conv_req),
   .pair_irq(pair_irq), .pair_done(pair_done));
`default_nettype wire
